// ===== core/csf_unit.sv
// Serial status slave and fault response logic of the charge manager
//
// Contract
// - Answer only 7-bit address 6A as slave; ignore other addresses.
// - Same protocol at 100 and 400 kbps.
// - Data line low past hang timeout: drop commands, engine to idle.
// - Hang timer restarts on each START, stops on valid STOP.
// - On address match hold data low through ninth clock high.
// - Direction 0 writes, 1 reads; receiver acknowledges each byte.
// - Reads of unimplemented register addresses return FF.
// - Bits 7:6 give ready, charging, done, fault; present status.
// - Write-only bit 5 resets 0; writing 1 requests storage state.
// - Bit 4 set on button reset, cleared when register is read.
// - Timer fault bit survives reads; clears on inhibit toggle or power.
// - Bit 1 mirrors the charge inhibit pin level.
// - Input over/undervoltage: flag, fault, interrupt, no PG, charge/TS off.
// - Input current limit: charging state, interrupt, keep charging, TS on.
// - Battery undervoltage: flag, fault, interrupt, force pre-charge.
// - Timer expiry: flag, fault, interrupt, charging and TS off.
// - Input loop active: flag, fault, interrupt, cut input current.
// - Cold or hot zone: record, fault, interrupt, charging off.
// - Cool zone: record, fault, interrupt, halve charge current.
// - Warm zone: record, fault, interrupt, lower regulation 140 mV.
// - Charge done: state, interrupt, charging off, watch recharge level.
// - Each interrupt is one 128 us pulse.
`timescale 1ns/10ps
module csf_unit
#(
	parameter int HANG_CYCLES = csf_pkg::HANG_CYCLES_DEF
)
(
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	input  wire logic          link_clk,
	input  wire logic          scl_i,
	input  wire logic          sda_i,
	output logic               sda_o,
	output logic               sda_oe,
	input  wire csf_pkg::csf_pins_t pins_i,
	output csf_pkg::csf_ctl_t  ctl_o,
	output logic               storage_state_request,
	output logic               int_pulse
);
	import csf_pkg::*;

	// System clock domain state
	typedef struct packed {
		csf_pins_t   s1;
		csf_pins_t   s2;
		csf_pins_t   p;
		logic [1:0]  stat;
		logic        timer_flag;
		logic        reset_fault;
		logic [7:0]  snap;
		logic        snap_tgl;
		logic [2:0]  ack_sy;
		logic [2:0]  rd_sy;
		logic [2:0]  wr_sy;
		logic        storage;
		csf_ctl_t    ctl;
		logic        pend;
		logic [10:0] pcnt;
		logic        irq;
	} csf_sys_t;

	// Link clock domain state
	typedef struct packed {
		logic        scl1;
		logic        scl2;
		logic        sclp;
		logic        sda1;
		logic        sda2;
		logic        sdap;
		csf_lstate_t st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic [7:0]  ptr;
		logic        first;
		logic        rw;
		logic        ack_ok;
		logic        active;
		logic [15:0] hang;
		logic        oe;
		logic [1:0]  snap_sy;
		logic        snap_seen;
		logic [7:0]  snap;
		logic        rd_tgl;
		logic        wr_tgl;
		logic        wr_bit;
	} csf_lnk_t;

	localparam csf_sys_t SYS_RST = '{
		s1: '0, s2: '0, p: '0, stat: CHG_READY, timer_flag: 1'b0,
		reset_fault: 1'b0, snap: STATUS_RESET, snap_tgl: 1'b0,
		ack_sy: '0, rd_sy: '0, wr_sy: '0, storage: STORAGE_RESET,
		ctl: '0, pend: 1'b0, pcnt: '0, irq: 1'b0};

	localparam csf_lnk_t LNK_RST = '{
		scl1: 1'b1, scl2: 1'b1, sclp: 1'b1, sda1: 1'b1, sda2: 1'b1,
		sdap: 1'b1, st: LS_IDLE, cnt: '0, sh: '0, tx: '0, ptr: '0,
		first: 1'b0, rw: 1'b0, ack_ok: 1'b0, active: 1'b0, hang: '0,
		oe: 1'b0, snap_sy: '0, snap_seen: 1'b0, snap: STATUS_RESET,
		rd_tgl: 1'b0, wr_tgl: 1'b0, wr_bit: 1'b0};

	localparam logic [10:0] PULSE_LAST = 11'(INT_PULSE_CYCLES - 1);
	localparam logic [15:0] HANG_LAST  = 16'(HANG_CYCLES - 1);

	csf_sys_t sys_q;
	csf_sys_t sys_d;
	csf_lnk_t lnk_q;
	csf_lnk_t lnk_d;

	// Fault response and status, system clock
	always_comb
	begin
		csf_pins_t  cur;
		logic       fault;
		logic       event_hit;
		logic       rd_ev;
		logic       wr_ev;
		logic [1:0] stat_n;
		stat_n = CHG_READY;
		sys_d = sys_q;
		// Two-flop synchronisers; only s2 and later are interpreted
		sys_d.s1     = pins_i;
		sys_d.s2     = sys_q.s1;
		sys_d.p      = sys_q.s2;
		cur          = sys_q.s2;
		sys_d.ack_sy = {sys_q.ack_sy[1:0], lnk_q.snap_seen};
		sys_d.rd_sy  = {sys_q.rd_sy[1:0], lnk_q.rd_tgl};
		sys_d.wr_sy  = {sys_q.wr_sy[1:0], lnk_q.wr_tgl};
		rd_ev        = sys_q.rd_sy[2] ^ sys_q.rd_sy[1];
		wr_ev        = sys_q.wr_sy[2] ^ sys_q.wr_sy[1];

		// Sticky timer fault; a new expiry beats an inhibit toggle
		if (cur.timer_exp && !sys_q.p.timer_exp)
			sys_d.timer_flag = 1'b1;
		else if (cur.inhibit != sys_q.p.inhibit)
			sys_d.timer_flag = 1'b0;

		// Button reset flag; set wins over the read clear
		if (cur.btn_reset && !sys_q.p.btn_reset)
			sys_d.reset_fault = 1'b1;
		else if (rd_ev)
			sys_d.reset_fault = 1'b0;

		// Present charge state, fault outranks done and charging
		fault = cur.ov | cur.uv | cur.bat_uv | sys_d.timer_flag
			| cur.vloop | (cur.ts != TS_NORMAL);
		if (fault)
			stat_n = CHG_FAULT;
		else if (cur.done)
			stat_n = CHG_DONE;
		else if (cur.charging || cur.ilim)
			stat_n = CHG_CHARGING;
		sys_d.stat = stat_n;
		// Charger steering
		sys_d.ctl.power_good   = !(cur.ov || cur.uv);
		sys_d.ctl.charge_en    = !(cur.ov || cur.uv || sys_d.timer_flag
			|| cur.ts == TS_COLD_HOT || cur.done
			|| cur.inhibit);
		sys_d.ctl.ts_mon_en    = !(cur.ov || cur.uv
			|| sys_d.timer_flag);
		sys_d.ctl.precharge    = cur.bat_uv;
		sys_d.ctl.half_current = cur.ts == TS_COOL;
		sys_d.ctl.vreg_drop    = cur.ts == TS_WARM;
		sys_d.ctl.in_current_cut = cur.vloop || cur.ilim;
		sys_d.ctl.recharge_mon = cur.done && !fault;

		// Storage request from a bus write to the status register
		if (wr_ev)
			sys_d.storage = sys_q.storage | lnk_q.wr_bit;

		// Interrupt only on edges, so a held condition gives one pulse
		event_hit = (cur.ov && !sys_q.p.ov) || (cur.uv && !sys_q.p.uv)
			|| (cur.ilim && !sys_q.p.ilim)
			|| (cur.bat_uv && !sys_q.p.bat_uv)
			|| (cur.timer_exp && !sys_q.p.timer_exp)
			|| (cur.vloop && !sys_q.p.vloop)
			|| (cur.ts != sys_q.p.ts && cur.ts != TS_NORMAL)
			|| (stat_n != sys_q.stat);
		if (sys_q.irq)
		begin
			if (sys_q.pcnt == PULSE_LAST)
				sys_d.irq = 1'b0;
			sys_d.pcnt = sys_q.pcnt + 11'h001;
			sys_d.pend = sys_q.pend | event_hit;
		end
		else if (sys_q.pend || event_hit)
		begin
			sys_d.irq  = 1'b1;
			sys_d.pcnt = 11'h000;
			sys_d.pend = 1'b0;
		end

		// Publish a fresh snapshot once the link has taken the last one
		if (sys_q.ack_sy[2] == sys_q.snap_tgl)
		begin
			sys_d.snap = {stat_n, 1'b0, sys_d.reset_fault,
				sys_d.timer_flag, cur.vloop, cur.inhibit,
				cur.rail_on};
			sys_d.snap_tgl = !sys_q.snap_tgl;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sys_q <= SYS_RST;
		else
			sys_q <= sys_d;
	end

	// Serial engine, oversampling the bus on the link clock
	always_comb
	begin
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic [7:0] rd_byte;
		scl   = lnk_q.scl2;
		sda   = lnk_q.sda2;
		rise  = scl && !lnk_q.sclp;
		fall  = !scl && lnk_q.sclp;
		start = scl && lnk_q.sclp && !sda && lnk_q.sdap;
		stop  = scl && lnk_q.sclp && sda && !lnk_q.sdap;
		rd_byte = (lnk_q.ptr == REG_STATUS) ? lnk_q.snap
			: UNMAPPED_BYTE;
		lnk_d = lnk_q;
		lnk_d.scl1 = scl_i;
		lnk_d.scl2 = lnk_q.scl1;
		lnk_d.sclp = lnk_q.scl2;
		lnk_d.sda1 = sda_i;
		lnk_d.sda2 = lnk_q.sda1;
		lnk_d.sdap = lnk_q.sda2;
		// Status snapshot handshake from the system side
		lnk_d.snap_sy = {lnk_q.snap_sy[0], sys_q.snap_tgl};
		if (lnk_q.snap_sy[1] != lnk_q.snap_seen)
		begin
			lnk_d.snap      = sys_q.snap;
			lnk_d.snap_seen = lnk_q.snap_sy[1];
		end

		// Hang timer counts only low time inside a transaction
		if (lnk_q.active && !sda)
			lnk_d.hang = lnk_q.hang + 16'h0001;
		else
			lnk_d.hang = 16'h0000;
		// Rates differ only in edge spacing, so one engine serves both
		case (lnk_q.st)
			LS_ADDR, LS_WR_DATA:
			begin
				if (rise)
				begin
					lnk_d.sh  = {lnk_q.sh[6:0], sda};
					lnk_d.cnt = lnk_q.cnt + 4'h1;
				end
				else if (fall && lnk_q.cnt == 4'h8)
				begin
					lnk_d.cnt = 4'h0;
					if (lnk_q.st == LS_ADDR)
					begin
						if (lnk_q.sh[7:1] == SLAVE_ADDR)
						begin
							lnk_d.oe = 1'b1;
							lnk_d.rw = lnk_q.sh[0];
							lnk_d.st = LS_ADDR_ACK;
						end
						else
							lnk_d.st = LS_IDLE;
					end
					else
					begin
						lnk_d.oe    = 1'b1;
						lnk_d.st    = LS_WR_ACK;
						lnk_d.first = 1'b0;
						if (lnk_q.first)
							lnk_d.ptr = lnk_q.sh;
						else if (lnk_q.ptr == REG_STATUS)
						begin
							lnk_d.wr_bit = lnk_q.sh[STORAGE_POS];
							lnk_d.wr_tgl = !lnk_q.wr_tgl;
						end
					end
				end
			end
			LS_ADDR_ACK:
			begin
				// Ack held until the ninth clock has fallen
				if (fall)
				begin
					if (lnk_q.rw)
					begin
						lnk_d.tx = rd_byte;
						lnk_d.oe = !rd_byte[7];
						lnk_d.st = LS_RD_DATA;
					end
					else
					begin
						lnk_d.oe    = 1'b0;
						lnk_d.first = 1'b1;
						lnk_d.st    = LS_WR_DATA;
					end
				end
			end
			LS_WR_ACK:
			begin
				if (fall)
				begin
					lnk_d.oe = 1'b0;
					lnk_d.st = LS_WR_DATA;
				end
			end
			LS_RD_DATA:
			begin
				if (rise)
					lnk_d.cnt = lnk_q.cnt + 4'h1;
				else if (fall)
				begin
					if (lnk_q.cnt == 4'h8)
					begin
						lnk_d.oe  = 1'b0;
						lnk_d.cnt = 4'h0;
						lnk_d.st  = LS_RD_ACK;
						if (lnk_q.ptr == REG_STATUS)
							lnk_d.rd_tgl = !lnk_q.rd_tgl;
					end
					else
					begin
						lnk_d.tx = {lnk_q.tx[6:0], 1'b1};
						lnk_d.oe = !lnk_q.tx[6];
					end
				end
			end
			LS_RD_ACK:
			begin
				// Master answers; a high level ends the read
				if (rise)
					lnk_d.ack_ok = !sda;
				else if (fall)
				begin
					if (lnk_q.ack_ok)
					begin
						lnk_d.tx = rd_byte;
						lnk_d.oe = !rd_byte[7];
						lnk_d.st = LS_RD_DATA;
					end
					else
						lnk_d.st = LS_IDLE;
				end
			end
			default:
				lnk_d.oe = 1'b0;
		endcase
		// START and STOP override any phase
		if (start)
		begin
			lnk_d.st     = LS_ADDR;
			lnk_d.cnt    = 4'h0;
			lnk_d.oe     = 1'b0;
			lnk_d.active = 1'b1;
			lnk_d.hang   = 16'h0000;
		end
		else if (stop || (lnk_q.active && lnk_q.hang == HANG_LAST))
		begin
			// Stop or stuck bus: release, then wait for a new START
			lnk_d.st     = LS_IDLE;
			lnk_d.oe     = 1'b0;
			lnk_d.active = 1'b0;
		end
	end

	always_ff @(posedge link_clk or negedge arst_n)
	begin
		if (!arst_n)
			lnk_q <= LNK_RST;
		else
			lnk_q <= lnk_d;
	end

	// Outputs straight from flops, sda_o tied low
	assign sda_o                 = 1'b0;   // Open drain: low or released
	assign sda_oe                = lnk_q.oe;
	assign ctl_o                 = sys_q.ctl;
	assign storage_state_request = sys_q.storage;
	assign int_pulse             = sys_q.irq;

endmodule : csf_unit

// ===== core/csf_pkg.sv
// Shared constants and types for the charger status and fault unit
package csf_pkg;

	// Bus addressing
	localparam logic [6:0] SLAVE_ADDR       = 7'h6a;
	localparam logic [7:0] REG_STATUS       = 8'h00;
	localparam logic [7:0] UNMAPPED_BYTE    = 8'hff;

	// Status register field positions
	localparam int         STAT_HI_POS      = 7;
	localparam int         STAT_LO_POS      = 6;
	localparam int         STORAGE_POS      = 5;
	localparam int         RESET_FAULT_POS  = 4;
	localparam int         TIMER_POS        = 3;
	localparam int         LOOP_POS         = 2;
	localparam int         INHIBIT_POS      = 1;
	localparam int         RAIL_POS         = 0;

	// Reset values
	localparam logic [7:0] STATUS_RESET     = 8'h01;
	localparam logic       STORAGE_RESET    = 1'b0;

	// Charge state encodings
	localparam logic [1:0] CHG_READY        = 2'h0;
	localparam logic [1:0] CHG_CHARGING     = 2'h1;
	localparam logic [1:0] CHG_DONE         = 2'h2;
	localparam logic [1:0] CHG_FAULT        = 2'h3;

	// Thermistor zone encodings
	localparam logic [1:0] TS_NORMAL        = 2'h0;
	localparam logic [1:0] TS_COLD_HOT      = 2'h1;
	localparam logic [1:0] TS_COOL          = 2'h2;
	localparam logic [1:0] TS_WARM          = 2'h3;

	// Timing: interrupt pulse on the system clock
	localparam int         SYS_CLK_MHZ      = 10;
	localparam int         INT_PULSE_US     = 128;
	localparam int         INT_PULSE_CYCLES = INT_PULSE_US * SYS_CLK_MHZ;

	// Timing: bus-hang timeout on the link clock
	localparam int         LINK_CLK_MHZ     = 166;
	localparam int         HANG_TIMEOUT_US  = 25;
	localparam int         HANG_CYCLES_DEF  = HANG_TIMEOUT_US * LINK_CLK_MHZ;

	// Serial engine states
	typedef enum logic [6:0] {
		LS_IDLE     = 7'h01,
		LS_ADDR     = 7'h02,
		LS_ADDR_ACK = 7'h04,
		LS_WR_DATA  = 7'h08,
		LS_WR_ACK   = 7'h10,
		LS_RD_DATA  = 7'h20,
		LS_RD_ACK   = 7'h40
	} csf_lstate_t;

	// Analog status pins, all asynchronous to sys_clk
	typedef struct packed {
		logic       ov;
		logic       uv;
		logic       ilim;
		logic       bat_uv;
		logic       timer_exp;
		logic       vloop;
		logic [1:0] ts;
		logic       done;
		logic       charging;
		logic       inhibit;
		logic       btn_reset;
		logic       rail_on;
	} csf_pins_t;

	// Charger steering outputs
	typedef struct packed {
		logic power_good;
		logic charge_en;
		logic ts_mon_en;
		logic precharge;
		logic half_current;
		logic vreg_drop;
		logic in_current_cut;
		logic recharge_mon;
	} csf_ctl_t;

endpackage : csf_pkg

// ===== sim/csf_unit_properties.sv
// Port-level checks on the status and fault unit
`timescale 1ns/10ps
module csf_unit_properties
#(
	parameter int HANG_CYCLES = 4150
)
(
	input wire logic               sys_clk,
	input wire logic               arst_n,
	input wire logic               link_clk,
	input wire logic               scl_i,
	input wire logic               sda_i,
	input wire logic               sda_o,
	input wire logic               sda_oe,
	input wire csf_pkg::csf_pins_t pins_i,
	input wire csf_pkg::csf_ctl_t  ctl_o,
	input wire logic               storage_state_request,
	input wire logic               int_pulse
);
	import csf_pkg::*;

	logic [10:0] hi_cnt_q;

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Length of the running interrupt pulse, zero from the second cycle it is low
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			hi_cnt_q <= 11'h000;
		else
			hi_cnt_q <= int_pulse ? hi_cnt_q + 11'h001 : 11'h000;

	// Pins are synced, so each steering response is given five samples to settle, the event pulse eight
	a_pulse_length: assert property ($fell(int_pulse) |->
		hi_cnt_q == 11'(INT_PULSE_CYCLES)) else $error("pulse length");
	a_pulse_cap: assert property (hi_cnt_q <= 11'(INT_PULSE_CYCLES))
		else $error("pulse too long");
	a_event_pulse: assert property ($rose(pins_i.ov) |-> ##[1:8] int_pulse)
		else $error("no pulse on event");
	a_input_shutoff: assert property ((pins_i.ov || pins_i.uv) [*5] |->
		!ctl_o.power_good && !ctl_o.charge_en && !ctl_o.ts_mon_en)
		else $error("input fault response");
	a_batuv_precharge: assert property (pins_i.bat_uv [*5] |-> ctl_o.precharge)
		else $error("no precharge");
	a_timer_shutoff: assert property (pins_i.timer_exp [*5] |->
		!ctl_o.charge_en && !ctl_o.ts_mon_en) else $error("timer response");
	a_vloop_cut: assert property (pins_i.vloop [*5] |-> ctl_o.in_current_cut)
		else $error("no input cut");
	a_zone_off: assert property (pins_i.ts == TS_COLD_HOT [*5] |-> !ctl_o.charge_en)
		else $error("charging in cold or hot");
	a_cool_half: assert property (pins_i.ts == TS_COOL [*5] |-> ctl_o.half_current)
		else $error("no half current");
	a_warm_drop: assert property (pins_i.ts == TS_WARM [*5] |-> ctl_o.vreg_drop)
		else $error("no voltage drop");
	a_done_off: assert property (pins_i.done [*5] |-> !ctl_o.charge_en)
		else $error("charging after done");
	a_storage_sticky: assert property (storage_state_request |=>
		storage_state_request) else $error("storage request lost");
endmodule : csf_unit_properties

bind csf_unit csf_unit_properties #(.HANG_CYCLES(HANG_CYCLES)) csf_unit_properties_i (
	.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .pins_i(pins_i),
	.ctl_o(ctl_o), .storage_state_request(storage_state_request),
	.int_pulse(int_pulse));

// ===== sim/csf_host_model.sv
// Two-wire bus master standing in for the host controller
`timescale 1ns/10ps
module csf_host_model
(
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	int half_ns = 1250; // 400 kbps; 5000 gives 100 kbps

	// Clock driven high and data released at start, the pull-up holds data high
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Data moves a quarter phase after the clock falls, never with it
	task automatic bit_io(input logic b, output logic s);
		#(half_ns / 4) sda_pull = !b;
		#(half_ns * 3 / 4) scl = 1'b1;
		#(half_ns / 2) s = sda;
		#(half_ns / 2) scl = 1'b0;
	endtask : bit_io

	// Receiver of each byte drives the ninth bit
	task automatic byte_io(input logic [7:0] d, input logic a_in,
		output logic [7:0] q, output logic a_out);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a_in, a_out);
	endtask : byte_io

	// Start or repeated start: data falls while the clock is high
	task automatic start;
		#(half_ns / 4) sda_pull = 1'b0;
		#(half_ns * 3 / 4) scl = 1'b1;
		#(half_ns) sda_pull = 1'b1;
		#(half_ns) scl = 1'b0;
	endtask : start

	// Every transfer, early ends too, closes with a stop
	task automatic stop;
		#(half_ns / 4) sda_pull = 1'b1;
		#(half_ns * 3 / 4) scl = 1'b1;
		#(half_ns) sda_pull = 1'b0;
		#(half_ns);
	endtask : stop

	// Misbehaving master: data held low with the clock parked low
	task automatic hold_low(input int ns);
		sda_pull = 1'b1;
		#(ns);
		sda_pull = 1'b0;
	endtask : hold_low
endmodule : csf_host_model

// ===== sim/csf_unit_tb.sv
// Self-checking bench for the status and fault unit
`timescale 1ns/10ps
module csf_unit_tb;
	import csf_pkg::*;

	localparam int HANG  = 30000;
	localparam int LIMIT = 100000;

	logic        sys_clk, link_clk, arst_n, scl, sda_pull;
	logic        sda_o, sda_oe, storage, int_pulse, prev_int, ak;
	wire logic   sda;
	csf_pins_t   pins;
	csf_ctl_t    ctl;
	int          n_fail, n_compared, cycles, rises;
	logic [7:0]  q;
	logic [37:0] rows [18];

	// Open-drain data wire with pull-up
	assign sda = !(sda_pull || (sda_oe && sda_o === 1'b0));

	csf_unit #(.HANG_CYCLES(HANG)) csf_unit_i (.sys_clk(sys_clk),
		.arst_n(arst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .pins_i(pins), .ctl_o(ctl),
		.storage_state_request(storage), .int_pulse(int_pulse));
	csf_host_model csf_host_model_i (.scl(scl), .sda_pull(sda_pull),
		.sda(sda));

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Link clock offset so its edges never line up with the system clock
	initial
	begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	// Cycle ceiling and pulse counter, away from the launching edge
	always @(negedge sys_clk)
	begin
		cycles++;
		if (int_pulse === 1'b1 && prev_int !== 1'b1)
			rises++;
		prev_int = int_pulse;
		if (cycles == LIMIT)
		begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	task automatic put(input logic [7:0] d, input logic exp_ack);
		logic [7:0] x;
		csf_host_model_i.byte_io(d, 1'b1, x, ak);
		check("ack", {7'h00, ak}, {7'h00, exp_ack});
	endtask : put

	// Pointer write, repeated start, one byte read, master refuses more
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		csf_host_model_i.start();
		put(8'hd4, 1'b0);
		put(a, 1'b0);
		csf_host_model_i.start();
		put(8'hd5, 1'b0);
		csf_host_model_i.byte_io(8'hff, 1'b1, d, ak);
		csf_host_model_i.stop();
	endtask : read_reg

	initial
	begin
		n_fail = 0;
		n_compared = 0;
		cycles = 0;
		rises = 0;
		arst_n = 1'b0;
		pins = 13'h0001;
		// Rows: pins, status, steering, steering mask, pulse expected
		rows = '{{13'h0009, 8'h41, 8'h60, 8'h60, 1'b1},
			{13'h0409, 8'h41, 8'h60, 8'h60, 1'b1},
			{13'h1001, 8'hc1, 8'h00, 8'he0, 1'b1},
			{13'h0801, 8'hc1, 8'h00, 8'he0, 1'b1},
			{13'h0201, 8'hc1, 8'h10, 8'h10, 1'b1},
			{13'h0089, 8'hc5, 8'h42, 8'h42, 1'b1},
			{13'h0021, 8'hc1, 8'h00, 8'h40, 1'b1},
			{13'h0049, 8'hc1, 8'h08, 8'h08, 1'b1},
			{13'h0069, 8'hc1, 8'h04, 8'h04, 1'b1},
			{13'h0011, 8'h81, 8'h01, 8'h41, 1'b1},
			{13'h0001, 8'h01, 8'h00, 8'h00, 1'b1},
			{13'h0101, 8'hc9, 8'h00, 8'h60, 1'b1},
			{13'h0001, 8'hc9, 8'h00, 8'h00, 1'b0},
			{13'h0005, 8'h03, 8'h00, 8'h40, 1'b1},
			{13'h0001, 8'h01, 8'h00, 8'h00, 1'b0},
			{13'h0003, 8'h11, 8'h00, 8'h00, 1'b0},
			{13'h0001, 8'h01, 8'h00, 8'h00, 1'b0},
			{13'h0001, 8'h01, 8'h00, 8'h00, 1'b0}};
		repeat (12) @(negedge sys_clk);
		arst_n = 1'b1;
		// Let any start-up pulse die away before the table
		repeat (2700) @(negedge sys_clk);
		foreach (rows[i])
		begin
			pins = rows[i][37:25];
			rises = 0;
			repeat (2600) @(negedge sys_clk);
			check("pulse", {7'h00, rises != 0}, {7'h00, rows[i][0]});
			check("steering", ctl & rows[i][8:1], rows[i][16:9]);
			read_reg(8'h00, q);
			check("status", q, rows[i][24:17]);
		end
		// Storage request at standard rate; the bit reads back as zero
		check("storage", {7'h00, storage}, 8'h00);
		csf_host_model_i.half_ns = 5000;
		csf_host_model_i.start();
		put(8'hd4, 1'b0);
		put(8'h00, 1'b0);
		put(8'h20, 1'b0);
		csf_host_model_i.stop();
		repeat (20) @(negedge sys_clk);
		check("storage", {7'h00, storage}, 8'h01);
		read_reg(8'h00, q);
		check("status", q, 8'h01);
		csf_host_model_i.half_ns = 1250;
		read_reg(8'h05, q);
		check("unmapped", q, 8'hff);
		// Foreign address is left unanswered
		csf_host_model_i.start();
		put(8'hd6, 1'b1);
		csf_host_model_i.stop();
		// Hung data line: the engine drops the transfer
		csf_host_model_i.start();
		put(8'hd4, 1'b0);
		csf_host_model_i.hold_low(200000);
		put(8'h00, 1'b1);
		csf_host_model_i.stop();
		read_reg(8'h00, q);
		check("status", q, 8'h01);
		// Second reset in mid-run
		arst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		check("reset", {4'h0, sda_oe, storage, int_pulse, |ctl}, 8'h00);
		repeat (12) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (30) @(negedge sys_clk);
		read_reg(8'h00, q);
		check("status", q, 8'h01);
		give_verdict();
	end
endmodule : csf_unit_tb
